// ==== hw/irw_pkg.sv ====
package irw_pkg;

	localparam int unsigned IRW_AW = 8;
	localparam int unsigned IRW_DW = 8;

	localparam logic [IRW_AW-1:0] IRW_ADDR_SOURCE = 8'h0c;
	localparam logic [IRW_AW-1:0] IRW_ADDR_CONFIG = 8'h2c;
	localparam logic [IRW_AW-1:0] IRW_ADDR_ENABLE = 8'h2d;
	localparam logic [IRW_AW-1:0] IRW_ADDR_STEER  = 8'h2e;

	localparam logic [IRW_DW-1:0] IRW_CONFIG_RST = 8'h00;
	localparam logic [IRW_DW-1:0] IRW_ENABLE_RST = 8'h00;
	localparam logic [IRW_DW-1:0] IRW_STEER_RST  = 8'h00;
	localparam logic [IRW_DW-1:0] IRW_ZERO       = 8'h00;

	localparam logic [IRW_DW-1:0] IRW_CONFIG_MASK = 8'hfb;
	localparam logic [IRW_DW-1:0] IRW_SRC_MASK    = 8'hfd;

	// Source bit positions, shared by enable, steering and source
	localparam int unsigned IRW_SRC_SLEEP_WAKE = 7;
	localparam int unsigned IRW_SRC_BUFFER     = 6;
	localparam int unsigned IRW_SRC_JOLT       = 5;
	localparam int unsigned IRW_SRC_ORIENT     = 4;
	localparam int unsigned IRW_SRC_PULSE      = 3;
	localparam int unsigned IRW_SRC_FALL       = 2;
	localparam int unsigned IRW_SRC_READY      = 0;

	// Config register fields
	localparam int unsigned IRW_CFG_BUF_GATE    = 7;
	localparam int unsigned IRW_CFG_WAKE_JOLT   = 6;
	localparam int unsigned IRW_CFG_WAKE_ORIENT = 5;
	localparam int unsigned IRW_CFG_WAKE_PULSE  = 4;
	localparam int unsigned IRW_CFG_WAKE_FALL   = 3;
	localparam int unsigned IRW_CFG_LEVEL       = 1;
	localparam int unsigned IRW_CFG_DRIVE       = 0;

	localparam int unsigned IRW_NPINS = 2;
	localparam int unsigned IRW_PIN_A = 0;
	localparam int unsigned IRW_PIN_B = 1;

	// Push-pull, active low, idle: pin high and driven
	localparam logic IRW_PIN_O_RST    = 1'b1;
	localparam logic IRW_PIN_OE_N_RST = 1'b0;

	typedef enum logic [1:0] {
		IRW_SEL_NONE,
		IRW_SEL_CONFIG,
		IRW_SEL_ENABLE,
		IRW_SEL_STEER
	} irw_wsel_t;

endpackage : irw_pkg

// ==== hw/irw_pin_drv.sv ====
`timescale 1ns/10ps
`default_nettype none
module irw_pin_drv
	import irw_pkg::*;
(
	input  wire logic ref_clk,    // Clock
	input  wire logic arst_n,     // Async reset
	input  wire logic active,     // Any routed enabled source set
	input  wire logic level_sel,  // 1 active high
	input  wire logic drive_type, // 1 open-drain
	output logic      pin_o,      // Pin output value
	output logic      pin_oe_n    // Low while driving
);

	typedef struct packed {
		logic pin_o;
		logic pin_oe_n;
	} irw_drv_st_t;

	irw_drv_st_t st_r;
	irw_drv_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.pin_o = active ? level_sel : ~level_sel;
		if (drive_type) begin
			// Open-drain only drives the asserted level
			st_nxt.pin_oe_n = ~active;
		end else begin
			st_nxt.pin_oe_n = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r.pin_o    <= IRW_PIN_O_RST;
			st_r.pin_oe_n <= IRW_PIN_OE_N_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_o    = st_r.pin_o;
	assign pin_oe_n = st_r.pin_oe_n;

endmodule : irw_pin_drv
`default_nettype wire

// ==== hw/irw_ctrl.sv ====
// Contract
// - With wake-on-orientation set, an enabled orientation event wakes the system in sleep; clear, it is ignored.
// - With wake-on-pulse set, an enabled pulse event wakes the system in sleep; clear, it is ignored.
// - With wake-on-fall-motion set, an enabled fall/motion event wakes the system in sleep; clear, it is ignored.
// - Config bit 1 sets the asserted level of both pins, 0 low (default), 1 high.
// - Config bit 0 makes both pins push-pull when 0 (default) or open-drain when 1.
// - Each enable bit gates its source's flag into the controller, 0 off (default), 1 on.
// - Enable bits are sleep/wake 7, buffer 6, jolt 5, orientation 4, pulse 3, fall/motion 2, ready 0, bit 1 unused.
// - A steering bit of 0 sends an enabled source to pin b, 1 to pin a.
// - The steering register has one bit per source at the enable positions, bit 1 unused.
// - All steering bits reset to 0 so every enabled source goes to pin b.
// - A pin is active while any enabled source steered to it has its flag set.
// - With wake-on-jolt set, an enabled jolt event wakes the system in sleep; clear, it is ignored.
// - The wake-source and pin-config register sits at 0x2c and is read/write.
`timescale 1ns/10ps
`default_nettype none
module irw_ctrl
	import irw_pkg::*;
(
	input  wire logic              ref_clk,     // 250 MHz clock
	input  wire logic              arst_n,      // Async reset, active low
	input  wire logic [IRW_AW-1:0] reg_addr,    // Register address
	input  wire logic [IRW_DW-1:0] reg_wdata,   // Write data
	input  wire logic              reg_wr,      // Write strobe
	input  wire logic              reg_rd,      // Read strobe
	output logic      [IRW_DW-1:0] reg_rdata,   // Read data, cycle after strobe
	input  wire logic [IRW_DW-1:0] evt_flag,    // Detection event flags, levels
	input  wire logic              sleep_mode,  // System is in sleep
	output logic                   wake_req,    // Wake request level
	output logic      [IRW_DW-1:0] irq_source,  // Enabled active sources
	output logic                   irq_pin_a_o,    // Pin a value
	output logic                   irq_pin_a_oe_n, // Pin a enable, low drives
	output logic                   irq_pin_b_o,    // Pin b value
	output logic                   irq_pin_b_oe_n  // Pin b enable, low drives
);

	typedef struct packed {
		logic [IRW_DW-1:0] config_r;
		logic [IRW_DW-1:0] enable_r;
		logic [IRW_DW-1:0] steer_r;
		logic [IRW_DW-1:0] source_r;
		logic [IRW_DW-1:0] rdata_r;
		logic              wake_r;
	} irw_st_t;

	irw_st_t st_r;
	irw_st_t st_nxt;

	// Used for both write select and read mux
	function automatic irw_wsel_t decode(input logic [IRW_AW-1:0] a);
		irw_wsel_t s;
		s = IRW_SEL_NONE;
		if (a == IRW_ADDR_CONFIG) begin
			s = IRW_SEL_CONFIG;
		end else if (a == IRW_ADDR_ENABLE) begin
			s = IRW_SEL_ENABLE;
		end else if (a == IRW_ADDR_STEER) begin
			s = IRW_SEL_STEER;
		end
		return s;
	endfunction : decode

	// Places wake-select bits at the source positions they guard
	function automatic logic [IRW_DW-1:0] wake_mask(input logic [IRW_DW-1:0] cfg);
		logic [IRW_DW-1:0] m;
		m = IRW_ZERO;
		m[IRW_SRC_JOLT]   = cfg[IRW_CFG_WAKE_JOLT];
		m[IRW_SRC_ORIENT] = cfg[IRW_CFG_WAKE_ORIENT];
		m[IRW_SRC_PULSE]  = cfg[IRW_CFG_WAKE_PULSE];
		m[IRW_SRC_FALL]   = cfg[IRW_CFG_WAKE_FALL];
		return m;
	endfunction : wake_mask

	logic [IRW_DW-1:0]    gated;
	logic [IRW_NPINS-1:0] pin_active;
	logic [IRW_NPINS-1:0] pin_o;
	logic [IRW_NPINS-1:0] pin_oe_n;
	irw_wsel_t            wsel;

	always_comb begin
		gated = evt_flag & st_r.enable_r & IRW_SRC_MASK;
		// Steering 1 selects pin a, 0 pin b; any routed source asserts
		pin_active[IRW_PIN_A] = |(gated & st_r.steer_r);
		pin_active[IRW_PIN_B] = |(gated & ~st_r.steer_r);
	end

	always_comb begin
		wsel = decode(reg_addr);
		st_nxt = st_r;
		st_nxt.source_r = gated;
		// Gated so a stale wake clears one cycle after sleep ends
		st_nxt.wake_r = sleep_mode & |(gated & wake_mask(st_r.config_r));
		if (reg_wr) begin
			case (wsel)
				IRW_SEL_CONFIG: st_nxt.config_r = reg_wdata & IRW_CONFIG_MASK;
				IRW_SEL_ENABLE: st_nxt.enable_r = reg_wdata & IRW_SRC_MASK;
				IRW_SEL_STEER:  st_nxt.steer_r  = reg_wdata & IRW_SRC_MASK;
				default:        st_nxt.config_r = st_r.config_r;
			endcase
		end
		st_nxt.rdata_r = IRW_ZERO;
		if (reg_rd) begin
			if (reg_addr == IRW_ADDR_SOURCE) begin
				st_nxt.rdata_r = st_r.source_r;
			end else begin
				case (wsel)
					IRW_SEL_CONFIG: st_nxt.rdata_r = st_r.config_r;
					IRW_SEL_ENABLE: st_nxt.rdata_r = st_r.enable_r;
					IRW_SEL_STEER:  st_nxt.rdata_r = st_r.steer_r;
					default:        st_nxt.rdata_r = IRW_ZERO;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r.config_r <= IRW_CONFIG_RST;
			st_r.enable_r <= IRW_ENABLE_RST;
			st_r.steer_r  <= IRW_STEER_RST;
			st_r.source_r <= IRW_ZERO;
			st_r.rdata_r  <= IRW_ZERO;
			st_r.wake_r   <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < IRW_NPINS; gi++) begin : g_pin
			irw_pin_drv u_drv (
				.ref_clk    (ref_clk),
				.arst_n     (arst_n),
				.active     (pin_active[gi]),
				.level_sel  (st_r.config_r[IRW_CFG_LEVEL]),
				.drive_type (st_r.config_r[IRW_CFG_DRIVE]),
				.pin_o      (pin_o[gi]),
				.pin_oe_n   (pin_oe_n[gi])
			);
		end
	endgenerate

	assign reg_rdata      = st_r.rdata_r;
	assign wake_req       = st_r.wake_r;
	assign irq_source     = st_r.source_r;
	assign irq_pin_a_o    = pin_o[IRW_PIN_A];
	assign irq_pin_a_oe_n = pin_oe_n[IRW_PIN_A];
	assign irq_pin_b_o    = pin_o[IRW_PIN_B];
	assign irq_pin_b_oe_n = pin_oe_n[IRW_PIN_B];

endmodule : irw_ctrl
`default_nettype wire

// ==== test/irw_ctrl_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module irw_ctrl_asserts
	import irw_pkg::*;
(
	input wire logic              ref_clk,        // Clock
	input wire logic              arst_n,         // Reset
	input wire logic [IRW_AW-1:0] reg_addr,       // Address
	input wire logic [IRW_DW-1:0] reg_wdata,      // Write data
	input wire logic              reg_wr,         // Write strobe
	input wire logic              reg_rd,         // Read strobe
	input wire logic [IRW_DW-1:0] reg_rdata,      // Read data
	input wire logic [IRW_DW-1:0] evt_flag,       // Event flags
	input wire logic              sleep_mode,     // Sleep
	input wire logic              wake_req,       // Wake request
	input wire logic [IRW_DW-1:0] irq_source,     // Sources
	input wire logic              irq_pin_a_o,    // Pin a
	input wire logic              irq_pin_a_oe_n, // Pin a enable
	input wire logic              irq_pin_b_o,    // Pin b
	input wire logic              irq_pin_b_oe_n  // Pin b enable
);
	logic [IRW_DW-1:0] cfg_r, en_r, st_r, rd_exp;
	logic              act_a, act_b;
	// Shadow copies built from bus writes alone
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			{cfg_r, en_r, st_r} <= {IRW_CONFIG_RST, IRW_ENABLE_RST, IRW_STEER_RST};
		end else if (reg_wr) begin
			if (reg_addr == IRW_ADDR_CONFIG) cfg_r <= reg_wdata & IRW_CONFIG_MASK;
			if (reg_addr == IRW_ADDR_ENABLE) en_r <= reg_wdata & IRW_SRC_MASK;
			if (reg_addr == IRW_ADDR_STEER) st_r <= reg_wdata & IRW_SRC_MASK;
		end
	end
	always_comb begin
		case (reg_addr)
			IRW_ADDR_SOURCE: rd_exp = irq_source;
			IRW_ADDR_CONFIG: rd_exp = cfg_r;
			IRW_ADDR_ENABLE: rd_exp = en_r;
			IRW_ADDR_STEER:  rd_exp = st_r;
			default:         rd_exp = IRW_ZERO;
		endcase
	end
	assign act_a = |(evt_flag & en_r & st_r);
	assign act_b = |(evt_flag & en_r & ~st_r);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	property p_src; irq_source == ($past(evt_flag) & $past(en_r)); endproperty
	a_src: assert property (p_src) else $error("source mismatch");
	property p_pa; !$past(cfg_r[0]) |-> !irq_pin_a_oe_n && irq_pin_a_o == ($past(act_a) ~^ $past(cfg_r[1])); endproperty
	a_pa: assert property (p_pa) else $error("pin a push-pull level");
	property p_pb; !$past(cfg_r[0]) |-> !irq_pin_b_oe_n && irq_pin_b_o == ($past(act_b) ~^ $past(cfg_r[1])); endproperty
	a_pb: assert property (p_pb) else $error("pin b push-pull level");
	property p_oda; $past(cfg_r[0]) |-> irq_pin_a_oe_n == !$past(act_a) && (irq_pin_a_oe_n || irq_pin_a_o == $past(cfg_r[1])); endproperty
	a_oda: assert property (p_oda) else $error("pin a open-drain");
	property p_odb; $past(cfg_r[0]) |-> irq_pin_b_oe_n == !$past(act_b) && (irq_pin_b_oe_n || irq_pin_b_o == $past(cfg_r[1])); endproperty
	a_odb: assert property (p_odb) else $error("pin b open-drain");
	property p_rd; reg_rd |=> reg_rdata == $past(rd_exp); endproperty
	a_rd: assert property (p_rd) else $error("read data");
	property p_idle; !reg_rd |=> reg_rdata == IRW_ZERO; endproperty
	a_idle: assert property (p_idle) else $error("read data not cleared");
	property p_wake; wake_req == $past(sleep_mode && |(evt_flag & en_r & {2'h0, cfg_r[6:3], 2'h0})); endproperty
	a_wake: assert property (p_wake) else $error("wake request");
	c_wake: cover property (wake_req);
	c_od: cover property (cfg_r[0] && act_a);
	c_src: cover property (reg_rd && reg_addr == IRW_ADDR_SOURCE);
endmodule : irw_ctrl_asserts
`default_nettype wire

// ==== test/irw_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module irw_host_model (
	input  wire logic pin_a_o,    // Pin a value
	input  wire logic pin_a_oe_n, // Pin a enable
	input  wire logic pin_b_o,    // Pin b value
	input  wire logic pin_b_oe_n, // Pin b enable
	output logic      line_a,     // Resolved wire a
	output logic      line_b      // Resolved wire b
);
	// Host pull-up: a released pin reads high
	assign line_a = pin_a_oe_n ? 1'b1 : pin_a_o;
	assign line_b = pin_b_oe_n ? 1'b1 : pin_b_o;
endmodule : irw_host_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench
	import irw_pkg::*;
;
	logic              ref_clk, arst_n, reg_wr, reg_rd, sleep_mode, rd_seen, wake_req;
	logic              pa_o, pa_oe_n, pb_o, pb_oe_n, line_a, line_b;
	logic [IRW_AW-1:0] reg_addr;
	logic [IRW_DW-1:0] reg_wdata, reg_rdata, evt_flag, irq_source, cfg, en, st, src;
	logic [IRW_DW-1:0] rd_q[$];
	int                miscompares, total_checks, cycles;
	irw_ctrl dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.evt_flag(evt_flag), .sleep_mode(sleep_mode), .wake_req(wake_req),
		.irq_source(irq_source), .irq_pin_a_o(pa_o), .irq_pin_a_oe_n(pa_oe_n),
		.irq_pin_b_o(pb_o), .irq_pin_b_oe_n(pb_oe_n));
	irw_host_model host_u (.pin_a_o(pa_o), .pin_a_oe_n(pa_oe_n), .pin_b_o(pb_o),
		.pin_b_oe_n(pb_oe_n), .line_a(line_a), .line_b(line_b));
	task automatic chk(input string nm, input logic [IRW_DW-1:0] e, input logic [IRW_DW-1:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_bit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [IRW_AW-1:0] a, input logic [IRW_DW-1:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [IRW_AW-1:0] a, input logic [IRW_DW-1:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		rd_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd
	function automatic logic pin_exp(input logic act);
		return act ? cfg[IRW_CFG_LEVEL] : (cfg[IRW_CFG_DRIVE] | ~cfg[IRW_CFG_LEVEL]);
	endfunction : pin_exp
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (rd_seen) chk("read data", rd_q.pop_front(), reg_rdata);
		rd_seen <= reg_rd;
		cycles++;
		// Whole run needs about 480 cycles
		if (cycles > 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		{arst_n, reg_wr, reg_rd, sleep_mode} = '0;
		{reg_addr, reg_wdata, evt_flag} = '0;
		void'($urandom(49584));
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(IRW_ADDR_CONFIG, 8'h00);
		rd(IRW_ADDR_ENABLE, 8'h00);
		rd(IRW_ADDR_STEER, 8'h00);
		wr(IRW_ADDR_CONFIG, 8'hff);
		wr(IRW_ADDR_ENABLE, 8'hff);
		wr(IRW_ADDR_STEER, 8'hff);
		wr(IRW_ADDR_SOURCE, 8'hff);
		wr(8'h55, 8'hff);
		rd(IRW_ADDR_CONFIG, 8'hfb);
		rd(IRW_ADDR_ENABLE, 8'hfd);
		rd(IRW_ADDR_STEER, 8'hfd);
		rd(IRW_ADDR_SOURCE, 8'h00);
		rd(8'h55, 8'h00);
		repeat (40) begin
			cfg = 8'($urandom);
			en  = 8'($urandom);
			st  = 8'($urandom);
			wr(IRW_ADDR_CONFIG, cfg);
			wr(IRW_ADDR_ENABLE, en);
			wr(IRW_ADDR_STEER, st);
			@(posedge ref_clk);
			evt_flag   <= 8'($urandom);
			sleep_mode <= 1'($urandom);
			repeat (2) @(posedge ref_clk);
			#1;
			src = evt_flag & en & IRW_SRC_MASK;
			chk("source", src, irq_source);
			chk_bit("pin a", pin_exp(|(src & st)), line_a);
			chk_bit("pin b", pin_exp(|(src & ~st)), line_b);
			chk_bit("wake", sleep_mode && |(src & {2'h0, cfg[6:3], 2'h0}), wake_req);
			rd(IRW_ADDR_SOURCE, src);
		end
		// Mid-run reset with flags still raised
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(IRW_ADDR_STEER, IRW_STEER_RST);
		rd(IRW_ADDR_SOURCE, IRW_ZERO);
		repeat (2) @(posedge ref_clk);
		wrap_up();
	end
endmodule : testbench
bind irw_ctrl irw_ctrl_asserts chk_u (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.evt_flag(evt_flag), .sleep_mode(sleep_mode), .wake_req(wake_req),
	.irq_source(irq_source), .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe_n(irq_pin_a_oe_n),
	.irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe_n(irq_pin_b_oe_n));
`default_nettype wire
